// ===== inc/eeprom_map.svh
// Constant map for the two-wire serial EEPROM slave
`ifndef EEPROM_MAP_SVH
`define EEPROM_MAP_SVH
`define DEV_TYPE_CODE 4'hA
`define DIR_READ 1'h1
`define PAGE_BYTES 16
`define BLOCK_BYTES 256
`define PROG_TIME_MS 10
`define CLK_KHZ 50000
`define PROG_CYCLES (`PROG_TIME_MS * `CLK_KHZ)
`define BIT_LAST 3'h7
`define LOW_NIB_ONE 4'h1
`endif

// ===== inc/eeprom_pkg.sv
// Types shared by the two-wire serial EEPROM slave
package eeprom_pkg;
  typedef enum logic [2:0] {
    st_idle, st_addr, st_word, st_wdata, st_rdata, st_wait_stop
  } bus_state_e;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } wr_word_s;
  typedef struct packed {
    logic strap_bit_low;
    logic strap_bit_mid;
    logic strap_bit_high;
  } straps_s;
endpackage : eeprom_pkg

// ===== design/eeprom_fifo.sv
// Small valid/ready FIFO holding pending page-write words
`timescale 1ns/1ps
module eeprom_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 16
) (
  input wire logic clk, // System clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic in_valid, // Word offered
  output logic in_ready, // Room for a word
  input wire logic [WIDTH-1:0] in_data, // Word in
  output logic out_valid, // Word available
  input wire logic out_ready, // Drain side takes word
  output logic [WIDTH-1:0] out_data // Word out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr;
  logic [AW:0] rptr;
  logic [AW:0] fill;
  assign fill = wptr - rptr;
  // Honest full and empty from the pointer difference
  assign in_ready = (fill != (AW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data = mem[rptr[AW-1:0]];
  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem[wptr[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wptr <= wptr + 1'b1;
      end
      if (out_valid && out_ready) begin
        rptr <= rptr + 1'b1;
      end
    end
  end
endmodule : eeprom_fifo

// ===== design/eeprom_slave.sv
// Two-wire serial EEPROM slave: framing, addressing, page write, busy window
`timescale 1ns/1ps
`include "eeprom_map.svh"
module eeprom_slave #(
  parameter bit LARGE = 1'b1, // Two page blocks when set
  parameter int PROG_CYCLES = `PROG_CYCLES, // Program window in clk cycles
  parameter int FIFO_DEPTH = `PAGE_BYTES // Pending page-write words
) (
  input wire logic clk, // 50 MHz system clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic scl, // Bus clock pin from master
  input wire logic sda_in, // Bus data pin level
  output logic sda_out, // Data drive value, always low
  output logic sda_oe, // High while pulling data low
  input wire eeprom_pkg::straps_s straps, // Strapped address inputs
  output logic busy // Internal program cycle running
);
  import eeprom_pkg::*;

  localparam int NBLK = LARGE ? 2 : 1;
  logic [7:0] mem [NBLK*`BLOCK_BYTES];

  // Two-flop synchronisers on the pins
  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic scl_d;
  logic sda_d;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      scl_d <= 1'h1;
      sda_d <= 1'h1;
    end else begin
      scl_s <= {scl_s[0], scl};
      sda_s <= {sda_s[0], sda_in};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  assign scl_rise = scl_s[1] && !scl_d;
  assign scl_fall = !scl_s[1] && scl_d;
  assign start_ev = scl_s[1] && scl_d && sda_d && !sda_s[1];
  assign stop_ev = scl_s[1] && scl_d && !sda_d && sda_s[1];

  // Address match: type code and straps; in larger variant the low bit is the page block, not compared
  function automatic logic addr_match(input logic [6:0] a, input straps_s s);
    logic ok;
    ok = (a[6:3] == `DEV_TYPE_CODE);
    ok = ok && (a[2] == s.strap_bit_high) && (a[1] == s.strap_bit_mid);
    if (!LARGE) begin
      ok = ok && (a[0] == s.strap_bit_low);
    end
    return ok;
  endfunction : addr_match

  bus_state_e state;
  logic [2:0] bitn;
  logic ack_phase;
  logic [7:0] shreg;
  logic [7:0] waddr;
  logic blk;
  logic [7:0] rbyte;
  logic have_words;
  logic prog;
  logic [$clog2(PROG_CYCLES+1)-1:0] prog_cnt;

  // FIFO carries page-write words to the array during the busy window
  wr_word_s fin;
  wr_word_s fout;
  logic fin_valid;
  logic fin_ready;
  logic fout_valid;
  logic fin_blk;
  logic fout_blk;
  logic drain;
  logic drop;
  assign drain = prog && fout_valid;
  // A full FIFO holds one whole page, so its oldest word has the offset of the
  // incoming one: discarding it gives the page roll-over overwrite
  assign drop = fin_valid && !fin_ready;
  eeprom_fifo #(.WIDTH($bits(wr_word_s) + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(fin_valid),
    .in_ready(fin_ready),
    .in_data({fin_blk, fin}),
    .out_valid(fout_valid),
    .out_ready(drain || drop),
    .out_data({fout_blk, fout})
  );

  // Array writes happen only while programming, after the STOP
  always_ff @(posedge clk) begin
    if (drain) begin
      mem[{(NBLK > 1 ? fout_blk : 1'b0), fout.addr}] <= fout.data;
    end
  end

  // Busy window: starts on STOP after written data, lasts the program time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prog <= 1'h0;
      prog_cnt <= '0;
      busy <= 1'h0;
    end else begin
      if (!prog && stop_ev && have_words && state != st_idle) begin
        prog <= 1'h1;
        prog_cnt <= '0;
        busy <= 1'h1;
      end else if (prog) begin
        if (prog_cnt == ($bits(prog_cnt))'(PROG_CYCLES - 1)) begin
          prog <= 1'h0;
          busy <= 1'h0;
        end else begin
          prog_cnt <= prog_cnt + 1'b1;
        end
      end
    end
  end

  // Bus protocol machine; forced to st_idle, not driving, while programming
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= st_idle;
      bitn <= 3'h0;
      ack_phase <= 1'h0;
      shreg <= 8'h00;
      waddr <= 8'h00;
      blk <= 1'h0;
      rbyte <= 8'h00;
      have_words <= 1'h0;
      fin_valid <= 1'h0;
      fin <= '0;
      fin_blk <= 1'h0;
      sda_oe <= 1'h0;
    end else begin
      // Word offer stands until the FIFO takes it
      if (fin_ready) begin
        fin_valid <= 1'h0;
      end
      if (prog) begin
        state <= st_idle;
        sda_oe <= 1'h0;
        have_words <= 1'h0;
      end else if (start_ev) begin
        state <= st_addr;
        bitn <= 3'h0;
        // The SCL fall that closes START must not count as a data bit
        ack_phase <= 1'h1;
        sda_oe <= 1'h0;
        have_words <= 1'h0;
      end else if (stop_ev) begin
        state <= st_idle;
        sda_oe <= 1'h0;
      end else if (state != st_idle && scl_rise && !ack_phase) begin
        shreg <= {shreg[6:0], sda_s[1]};
      end else if (state != st_idle && scl_rise && ack_phase && state == st_rdata) begin
        if (sda_s[1]) begin
          state <= st_wait_stop;
        end
      end else if (state != st_idle && scl_fall) begin
        if (ack_phase) begin
          ack_phase <= 1'h0;
          bitn <= 3'h0;
          sda_oe <= 1'h0;
          if (state == st_rdata) begin
            sda_oe <= !rbyte[7];
          end
        end else if (bitn != `BIT_LAST) begin
          bitn <= bitn + 1'b1;
          if (state == st_rdata) begin
            rbyte <= {rbyte[6:0], 1'b1};
            sda_oe <= !rbyte[6];
          end
        end else begin
          ack_phase <= 1'h1;
          sda_oe <= 1'h0;
          unique case (state)
            st_addr: begin
              if (addr_match(shreg[7:1], straps)) begin
                sda_oe <= 1'h1;
                blk <= LARGE ? shreg[1] : 1'b0;
                if (shreg[0] == `DIR_READ) begin
                  state <= st_rdata;
                  rbyte <= mem[{(NBLK > 1 ? (LARGE ? shreg[1] : 1'b0) : 1'b0), waddr}];
                end else begin
                  state <= st_word;
                end
              end else begin
                state <= st_wait_stop;
              end
            end
            st_word: begin
              waddr <= shreg;
              sda_oe <= 1'h1;
              state <= st_wdata;
            end
            st_wdata: begin
              sda_oe <= 1'h1;
              fin_valid <= 1'h1;
              fin <= '{addr: waddr, data: shreg};
              fin_blk <= blk;
              have_words <= 1'h1;
              waddr <= {waddr[7:4], waddr[3:0] + `LOW_NIB_ONE};
            end
            st_rdata: begin
              waddr <= waddr + 1'b1;
              rbyte <= mem[{(NBLK > 1 ? blk : 1'b0), waddr + 1'b1}];
            end
            st_idle, st_wait_stop: begin
              sda_oe <= 1'h0;
            end
          endcase
        end
      end
    end
  end

  // Open-drain: the driven value is always low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_out <= 1'h0;
    end else begin
      sda_out <= 1'h0;
    end
  end
endmodule : eeprom_slave

// ===== tb/eeprom_slave_sva.sv
// Pin-level checker for the EEPROM slave
`timescale 1ns/1ps
module eeprom_slave_sva #(
  parameter int PROG_CYCLES = 200 // Program window in clk cycles
) (
  input wire logic clk, // System clock
  input wire logic rst, // Async reset
  input wire logic scl, // Bus clock pin
  input wire logic sda_in, // Resolved data wire
  input wire logic sda_out, // Drive value
  input wire logic sda_oe, // Drive enable
  input wire logic busy // Program window
);
  logic [31:0] cnt;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // Length of the current program window
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      cnt <= '0;
    else
      cnt <= busy ? cnt + 1 : '0;
  end
  sequence start_s;
    scl && $fell(sda_in);
  endsequence
  sequence idle_s;
    scl && sda_in;
  endsequence
  chk_drive_low_only: assert property (sda_oe |-> !sda_out) else $error("sda driven high");
  chk_busy_quiet: assert property (busy |-> !sda_oe) else $error("drive while busy");
  chk_oe_clock_low: assert property ($changed(sda_oe) |-> !scl) else $error("oe moved, scl high");
  chk_busy_holds: assert property ($rose(busy) |-> busy[*8]) else $error("busy too short");
  chk_busy_bound: assert property (cnt <= PROG_CYCLES) else $error("program too long");
  chk_busy_full: assert property ($fell(busy) |-> cnt == PROG_CYCLES) else $error("short");
  chk_busy_at_stop: assert property ($rose(busy) |-> idle_s) else $error("busy not at stop");
  chk_start_deaf: assert property (start_s ##0 busy |=> (!sda_oe)[*8]) else $error("busy ack");
endmodule : eeprom_slave_sva
bind eeprom_slave eeprom_slave_sva #(.PROG_CYCLES(PROG_CYCLES)) u_sva (.clk(clk), .rst(rst),
  .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .busy(busy));

// ===== tb/i2c_master_model.sv
// Bus master model for the two-wire pins, timed apart from clk
`timescale 1ns/1ps
module i2c_master_model (
  output logic scl, // Bus clock, high when idle
  output logic sda_m, // Master data, 1 releases
  input wire logic sda_w // Resolved data wire
);
  localparam time Q = 40ns;
  // Idle bus: clock stands high outside frames
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // Data moves mid-low so the synchronised view never sees a false edge
  task automatic bit_io(input logic b, output logic r);
    #Q sda_m = b;
    #Q scl = 1'b1;
    #Q r = sda_w;
    #Q scl = 1'b0;
  endtask : bit_io
  task automatic start();
    #Q sda_m = 1'b1;
    #Q scl = 1'b1;
    #Q sda_m = 1'b0;
    #Q scl = 1'b0;
  endtask : start
  task automatic stop();
    #Q sda_m = 1'b0;
    #Q scl = 1'b1;
    #Q sda_m = 1'b1;
    #Q;
  endtask : stop
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : put_byte
  task automatic get_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(!ack, r);
  endtask : get_byte
endmodule : i2c_master_model

// ===== tb/testbench.sv
// Self-checking bench for the EEPROM slave
`timescale 1ns/1ps
`define CHECK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  import eeprom_pkg::*;
  localparam int PC = 200;
  logic clk = 0, rst = 1, scl, sda_m, sda_out, sda_oe, busy, sda_w;
  logic [7:0] got, d [17];
  logic [7:0] exp_q [$];
  straps_s st = '0;
  int n_fail = 0, checks_done = 0, seed = 32'h0f15f2cb;
  event res_ev;
  always #10 clk = ~clk;
  // Pull-up on the data wire; either party may pull low
  assign sda_w = sda_m & (sda_oe ? sda_out : 1'b1);
  eeprom_slave #(.LARGE(1'b1), .PROG_CYCLES(PC), .FIFO_DEPTH(16)) DUT (.clk(clk), .rst(rst),
    .scl(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .straps(st), .busy(busy));
  i2c_master_model m (.scl(scl), .sda_m(sda_m), .sda_w(sda_w));
  // Each result is matched against the oldest note
  logic [7:0] exp_v;
  always @(res_ev) begin
    exp_v = exp_q.pop_front();
    `CHECK(got, exp_v)
  end
  task automatic res(input logic [7:0] g, input logic [7:0] e);
    exp_q.push_back(e);
    got = g;
    ->res_ev;
  endtask : res
  task automatic wb(input logic [7:0] b, input logic e);
    logic a;
    m.put_byte(b, a);
    res({7'h00, a}, {7'h00, e});
  endtask : wb
  task automatic rb(input logic [7:0] e, input logic ack);
    logic [7:0] v;
    m.get_byte(ack, v);
    res(v, e);
  endtask : rb
  // Type code, straps, block, direction in that order
  function automatic logic [7:0] sa(input int blk, input int rw);
    return {4'hA, st.strap_bit_high, st.strap_bit_mid, blk[0], rw[0]};
  endfunction : sa
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  // Busy must rise after a write and fall within a bounded wait
  task automatic wait_free();
    int i;
    repeat (8) @(negedge clk);
    res({7'h00, busy}, 8'h01);
    for (i = 0; i < 4000 && busy !== 1'b0; i++)
      @(negedge clk);
    if (i == 4000) begin
      n_fail++;
      tally_and_finish();
    end
  endtask : wait_free
  initial begin
    #500us;
    n_fail++;
    tally_and_finish();
  end
  // One device of 4K bits on the bus keeps the total at or below 16K
  initial begin
    repeat (19) @(negedge clk);
    st.strap_bit_mid = 1'($random(seed));
    st.strap_bit_high = 1'($random(seed));
    foreach (d[i])
      d[i] = 8'($random(seed));
    @(negedge clk) rst = 1'b0;
    repeat (4) @(negedge clk);
    for (int c = 0; c < 18; c++) begin
      m.start();
      if (c < 16)
        wb({c[3:0], st.strap_bit_high, st.strap_bit_mid, 2'b00}, c == 10);
      else
        wb(sa(0, 0) ^ (c == 16 ? 8'h08 : 8'h04), 1'b0);
      m.stop();
    end
    m.start();
    wb(sa(0, 0), 1'b1);
    wb(8'h30, 1'b1);
    wb(~d[0], 1'b1);
    m.stop();
    m.start();
    wb(sa(0, 0), 1'b0);
    m.stop();
    wait_free();
    m.start();
    wb(sa(1, 0), 1'b1);
    wb(8'h30, 1'b1);
    for (int i = 0; i < 17; i++)
      wb(d[i], 1'b1);
    m.stop();
    wait_free();
    m.start();
    wb(sa(1, 0), 1'b1);
    wb(8'h30, 1'b1);
    m.start();
    wb(sa(1, 1), 1'b1);
    for (int i = 0; i < 16; i++)
      rb(i == 0 ? d[16] : d[i], i < 15);
    rb(8'hFF, 1'b0);
    m.stop();
    m.start();
    wb(sa(0, 0), 1'b1);
    wb(8'h30, 1'b1);
    m.start();
    wb(sa(0, 1), 1'b1);
    rb(~d[0], 1'b0);
    m.stop();
    repeat (10) @(negedge clk);
    tally_and_finish();
  end
endmodule : testbench
